// ### verilog/apac_ctrl.sv
`timescale 1ns/10ps
// Contract
// - Page accesses change only the three low address lines.
// - Continued page reads end with chip select high within 4 us.
// - Chip select low without upper address change lasts at most 1000 ns.
// - Write pulse spans latest fall to earliest rise of select strobes.
// - Write cycle at least 70 ns, pulse plus recovery, under 1000 ns.
// - Write pulse held low at least 45 ns.
// - No write pulse inside a read started by output enable.
// - Output enable is high before a write address becomes valid.
// - Output enable low through a write only in select-driven sequences.
// - Address lines settle within 10 ns of any change.
// - Power-down: setup 10 ns, then control held low 70 ns.
// - Deep power-down exit and power-up: select high 300 us.
// - Partial retention exit: select high 1 us after control rises.
// - Write enable stays high 10 ns after chip select rises.
// - All address lines high in program cycles one to five.
// - Fifth-cycle value and sixth-cycle address use defined codes.
// - Sequence: read top, write it twice, write zero, config, read.
// - Config value bits 1:0 pick the mode, all others zero.
// - Config address low bits high, top two bits pick the mode.
module apac_ctrl import apac_pkg::*; #(
  parameter int unsigned AW = ADDR_W,
  parameter int unsigned DW = DATA_W,
  parameter int unsigned PAGE_N = PAGE_WORDS,
  parameter int unsigned TMR_W = 16,
  parameter int unsigned DEEP_WAKE_CYCLES = DEEP_WAKE_CYC
) (
  input wire logic core_clk, // Core clock, 10 MHz
  input wire logic rstn, // Async reset, active low
  input wire logic req_valid, // Request offered
  output logic req_ready, // Request may be taken
  input wire logic [2:0] req_cmd, // Command code
  input wire logic [AW-1:0] req_addr, // Word address
  input wire logic [DW-1:0] req_wdata, // Write data
  input wire logic [1:0] req_be, // Byte enables, bit 1 upper
  input wire logic [1:0] req_mode, // Mode for program command
  output logic rsp_valid, // Read word returned
  output logic [DW-1:0] rsp_rdata, // Read word
  output logic sleeping, // Memory is in power-down
  output logic [1:0] pd_mode, // Mode now programmed
  output logic chip_select_n, // Chip select, active low
  output logic sleep_control, // Power-down control, low sleeps
  output logic out_en_n, // Output enable, active low
  output logic write_en_n, // Write enable, active low
  output logic upper_byte_sel_n, // Upper byte select, active low
  output logic lower_byte_sel_n, // Lower byte select, active low
  output logic [AW-1:0] addr_lines, // Address
  input wire logic [DW-1:0] data_lines_i, // Data from memory
  output logic [DW-1:0] data_lines_o, // Data to memory
  output logic data_lines_oe // High while driving data
);

  localparam int unsigned PB = $clog2(PAGE_N);

  apac_state_t state_q, state_d;
  logic take, tmr_done, tmr_load, page_more, prog_adv, rsp_d;
  logic [TMR_W-1:0] tmr_val, wake_val;
  logic prog_q, page_q;
  logic [2:0] step_q, step_nxt;
  logic [1:0] prog_mode_q, cfg_mode_q, be_q, be_d;
  logic [PB-1:0] beat_q;
  logic [AW-1:0] addr_q, addr_d, cfg_addr;
  logic [DW-1:0] wdata_q, wdata_d, rda_q, cfg_data, rdata_q;
  logic ready_q, ready_d, rsp_q;
  logic cs_n_q, sleep_q, oe_n_q, we_n_q, ub_n_q, lb_n_q, doe_q, slp_q;
  logic cs_n_d, oe_n_d, we_n_d, sleep_d, doe_d;

  apac_timer #(
    .W(TMR_W),
    .RST_VAL(DEEP_WAKE_CYCLES - 1)
  ) u_timer (
    .core_clk(core_clk),
    .rstn(rstn),
    .load(tmr_load),
    .load_val(tmr_val),
    .done(tmr_done)
  );

  apac_pdc_map #(
    .AW(AW),
    .DW(DW)
  ) u_map (
    .mode(prog_mode_q),
    .cfg_data(cfg_data),
    .cfg_addr(cfg_addr)
  );

  // Request handshake and sequencing terms
  assign take = req_valid && ready_q;
  assign page_more = page_q && (beat_q != PB'(PAGE_N - 1));
  assign prog_adv = (state_q == ST_GAP) && tmr_done && prog_q;
  assign step_nxt = step_q + 3'h1;
  assign rsp_d = (state_q == ST_RD_DATA) &&
                 !(prog_q && step_q == PROG_RD_TOP);

  // Wake wait depends on the mode the memory slept in
  assign wake_val = (cfg_mode_q == PD_DEEP) ?
                    TMR_W'(DEEP_WAKE_CYCLES - 1) :
                    TMR_W'(PAR_WAKE_CYC - 1);

  // Timer restarts on every state change
  assign tmr_load = (state_d != state_q);
  assign tmr_val = (state_d == ST_WR_PULSE) ? TMR_W'(WP_CYC - 1) :
                   (state_d == ST_PD_SETUP) ? TMR_W'(PD_SETUP_CYC - 1) :
                   (state_d == ST_PD_SLEEP) ? TMR_W'(PD_HOLD_CYC - 1) :
                   (state_d == ST_WAKE) ? wake_val :
                   TMR_W'(CP_CYC - 1);

  // Sequencer; every access closes through a select-high gap
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_PWRUP: begin
        if (tmr_done) state_d = ST_IDLE;
      end
      ST_IDLE: begin
        if (take) begin
          if (req_cmd == CMD_READ || req_cmd == CMD_PAGE ||
              req_cmd == CMD_PROG) begin
            state_d = ST_RD_ADDR;
          end else if (req_cmd == CMD_WRITE) begin
            state_d = ST_WR_SET;
          end else if (req_cmd == CMD_SLEEP) begin
            state_d = ST_PD_SETUP;
          end
        end
      end
      ST_RD_ADDR: state_d = ST_RD_OE;
      ST_RD_OE: state_d = ST_RD_DATA;
      ST_RD_DATA: begin
        if (!page_more) state_d = ST_GAP;
      end
      ST_WR_SET: state_d = ST_WR_PULSE;
      ST_WR_PULSE: begin
        if (tmr_done) state_d = ST_WR_END;
      end
      ST_WR_END: state_d = ST_GAP;
      ST_GAP: begin
        if (tmr_done) begin
          if (prog_q && step_q != PROG_LAST) begin
            // Steps one to four write, step five reads
            state_d = (step_nxt == PROG_LAST) ? ST_RD_ADDR : ST_WR_SET;
          end else begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_PD_SETUP: begin
        if (tmr_done) state_d = ST_PD_SLEEP;
      end
      ST_PD_SLEEP: begin
        if (take && req_cmd == CMD_WAKE) state_d = ST_WAKE;
      end
      ST_WAKE: begin
        if (tmr_done) state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Ready only where a request can be taken; sleep waits out the hold
  assign ready_d = (state_d == ST_IDLE) ||
                   (state_q == ST_PD_SLEEP && state_d == ST_PD_SLEEP &&
                    tmr_done);

  // Address: request, page step, or program address
  assign addr_d = (take && state_q == ST_IDLE) ?
                  ((req_cmd == CMD_PROG) ? {AW{1'b1}} : req_addr) :
                  (state_q == ST_RD_DATA && page_more) ?
                  {addr_q[AW-1:PB], addr_q[PB-1:0] + PB'(1)} :
                  (prog_adv && step_nxt == PROG_LAST) ? cfg_addr :
                  addr_q;

  // Write data: request, read-back copy, zero or config value
  assign wdata_d = (take && state_q == ST_IDLE) ? req_wdata :
                   !prog_adv ? wdata_q :
                   (step_nxt == PROG_ZERO) ? {DW{1'b0}} :
                   (step_nxt == PROG_CFG) ? cfg_data :
                   rda_q;

  assign be_d = (take && state_q == ST_IDLE) ?
                ((req_cmd == CMD_PROG) ? 2'h3 : req_be) : be_q;

  // Pin levels follow the next state so every pin comes from a flop
  assign cs_n_d = !(state_d inside {ST_RD_ADDR, ST_RD_OE, ST_RD_DATA,
                                     ST_WR_SET, ST_WR_PULSE, ST_WR_END});
  // Output enable never low in write states, so no read in a write
  assign oe_n_d = !(state_d inside {ST_RD_OE, ST_RD_DATA});
  // Write enable falls last and rises first of the strobes
  assign we_n_d = (state_d != ST_WR_PULSE);
  assign sleep_d = (state_d != ST_PD_SLEEP);
  assign doe_d = state_d inside {ST_WR_SET, ST_WR_PULSE, ST_WR_END};

  // Sequencer and datapath registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_PWRUP;
      ready_q <= 1'b0;
      addr_q <= {AW{1'b1}};
      wdata_q <= {DW{1'b0}};
      be_q <= 2'h0;
    end else begin
      state_q <= state_d;
      ready_q <= ready_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      be_q <= be_d;
    end
  end

  // Page beat counter
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      page_q <= 1'b0;
      beat_q <= '0;
    end else if (take && state_q == ST_IDLE) begin
      page_q <= (req_cmd == CMD_PAGE);
      beat_q <= '0;
    end else if (state_q == ST_RD_DATA && page_more) begin
      beat_q <= beat_q + PB'(1);
    end
  end

  // Program sequence step and the mode it commits
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prog_q <= 1'b0;
      step_q <= PROG_RD_TOP;
      prog_mode_q <= PD_DEEP;
      cfg_mode_q <= PD_DEEP;
    end else if (take && state_q == ST_IDLE && req_cmd == CMD_PROG) begin
      prog_q <= 1'b1;
      step_q <= PROG_RD_TOP;
      prog_mode_q <= req_mode;
    end else if (prog_adv) begin
      if (step_q == PROG_LAST) begin
        prog_q <= 1'b0;
        cfg_mode_q <= prog_mode_q;
      end else begin
        step_q <= step_nxt;
      end
    end
  end

  // Read capture; the first program read is kept, not returned
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rsp_q <= 1'b0;
      rdata_q <= {DW{1'b0}};
      rda_q <= {DW{1'b0}};
    end else begin
      rsp_q <= rsp_d;
      if (rsp_d) rdata_q <= data_lines_i;
      if (state_q == ST_RD_DATA && !rsp_d) rda_q <= data_lines_i;
    end
  end

  // Pin registers; flop outputs change together at the clock edge
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cs_n_q <= 1'b1;
      sleep_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      ub_n_q <= 1'b1;
      lb_n_q <= 1'b1;
      doe_q <= 1'b0;
      slp_q <= 1'b0;
    end else begin
      cs_n_q <= cs_n_d;
      sleep_q <= sleep_d;
      oe_n_q <= oe_n_d;
      we_n_q <= we_n_d;
      ub_n_q <= cs_n_d | ~be_d[1];
      lb_n_q <= cs_n_d | ~be_d[0];
      doe_q <= doe_d;
      slp_q <= !sleep_d;
    end
  end

  assign req_ready = ready_q;
  assign rsp_valid = rsp_q;
  assign rsp_rdata = rdata_q;
  assign sleeping = slp_q;
  assign pd_mode = cfg_mode_q; // Partial modes keep data from zero
  assign chip_select_n = cs_n_q;
  assign sleep_control = sleep_q;
  assign out_en_n = oe_n_q;
  assign write_en_n = we_n_q;
  assign upper_byte_sel_n = ub_n_q;
  assign lower_byte_sel_n = lb_n_q;
  assign addr_lines = addr_q;
  assign data_lines_o = wdata_q;
  assign data_lines_oe = doe_q;

  // Helper counters for the timing checks below
  int unsigned cs_low_cnt_q, sleep_age_q, wake_need;
  assign wake_need = (cfg_mode_q == PD_DEEP) ? DEEP_WAKE_CYCLES : PAR_WAKE_CYC;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cs_low_cnt_q <= 0;
      sleep_age_q <= 0;
    end else begin
      cs_low_cnt_q <= chip_select_n ? 0 : cs_low_cnt_q + 1;
      if (!sleep_control) sleep_age_q <= 0;
      else if (sleep_age_q != 32'hffffffff) sleep_age_q <= sleep_age_q + 1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  property p_page_upper;
    !chip_select_n && !$past(chip_select_n) |->
      $stable(addr_lines[AW-1:PB]);
  endproperty
  a_page_upper: assert property (p_page_upper) else $error("upper addr moved");

  property p_cs_low_max;
    !chip_select_n |-> cs_low_cnt_q < RC_MAX_CYC;
  endproperty
  a_cs_low_max: assert property (p_cs_low_max) else $error("select low too long");

  property p_page_close;
    !chip_select_n |-> cs_low_cnt_q < PAGE_CLOSE_CYC;
  endproperty
  a_page_close: assert property (p_page_close) else $error("page not closed");

  property p_we_pulse;
    $fell(write_en_n) |-> !chip_select_n &&
      (!upper_byte_sel_n || !lower_byte_sel_n) ##1
      write_en_n && !chip_select_n;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("bad write pulse");

  property p_wr_recovery;
    $rose(write_en_n) |-> !chip_select_n ##1 chip_select_n && write_en_n;
  endproperty
  a_wr_recovery: assert property (p_wr_recovery) else $error("bad recovery");

  property p_no_read_write;
    !write_en_n |-> out_en_n && $past(out_en_n) && $past(out_en_n, 2);
  endproperty
  a_no_read_write: assert property (p_no_read_write) else $error("oe low in write");

  property p_standby_we;
    $rose(chip_select_n) |-> write_en_n ##1 write_en_n;
  endproperty
  a_standby_we: assert property (p_standby_we) else $error("we low at standby");

  property p_pd_entry;
    $fell(sleep_control) |-> $past(chip_select_n) && chip_select_n ##1
      !sleep_control && chip_select_n;
  endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("bad power-down entry");

  property p_wake_wait;
    $fell(chip_select_n) |-> sleep_age_q >= wake_need;
  endproperty
  a_wake_wait: assert property (p_wake_wait) else $error("wake wait too short");

  property p_prog_addr;
    prog_q && step_q != PROG_LAST && !chip_select_n |-> &addr_lines;
  endproperty
  a_prog_addr: assert property (p_prog_addr) else $error("program addr not high");

  property p_prog_cfg;
    prog_q && step_q == PROG_CFG && !write_en_n |->
      data_lines_oe && data_lines_o == {{(DW-2){1'b0}}, prog_mode_q};
  endproperty
  a_prog_cfg: assert property (p_prog_cfg) else $error("bad config value");

  property p_prog_cfg_addr;
    prog_q && step_q == PROG_LAST && !chip_select_n |->
      addr_lines == {prog_mode_q[0], prog_mode_q[1], {(AW-2){1'b1}}};
  endproperty
  a_prog_cfg_addr: assert property (p_prog_cfg_addr) else $error("bad config addr");

  property p_sleep_active;
    !chip_select_n |-> sleep_control;
  endproperty
  a_sleep_active: assert property (p_sleep_active) else $error("access in sleep");

  property p_prog_done;
    $rose(chip_select_n) && prog_q && step_q == PROG_LAST |=>
      chip_select_n && !prog_q;
  endproperty
  a_prog_done: assert property (p_prog_done) else $error("program not closed");

  c_page: cover property (state_q == ST_RD_DATA && page_q && !page_more);
  c_write: cover property ($rose(write_en_n));
  c_prog: cover property (prog_adv && step_q == PROG_LAST);
  c_wake: cover property ($rose(sleep_control) && cfg_mode_q != PD_DEEP);

endmodule

// ### verilog/apac_pkg.sv
package apac_pkg;

  // Core clock period
  localparam int unsigned CLK_PERIOD_NS = 100;

  // Least times round up, never below one cycle
  function automatic int unsigned ns_ceil(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c == 0) ? 1 : c;
  endfunction

  // Longest times round down, never below one cycle
  function automatic int unsigned ns_floor(input int unsigned ns);
    int unsigned c;
    c = ns / CLK_PERIOD_NS;
    return (c == 0) ? 1 : c;
  endfunction

  // Bus geometry
  localparam int unsigned ADDR_W = 21;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned PAGE_WORDS = 8;

  // Pin timing, in printed units
  localparam int unsigned T_WP_NS = 45;
  localparam int unsigned T_CP_NS = 15;
  localparam int unsigned T_RC_MAX_NS = 1000;
  localparam int unsigned T_PAGE_CLOSE_US = 4;
  localparam int unsigned T_PD_SETUP_NS = 10;
  localparam int unsigned T_PD_HOLD_NS = 70;
  localparam int unsigned T_DEEP_WAKE_US = 300;
  localparam int unsigned T_PAR_WAKE_US = 1;

  // Same timing in core clock cycles
  localparam int unsigned WP_CYC = ns_ceil(T_WP_NS);
  localparam int unsigned CP_CYC = ns_ceil(T_CP_NS);
  localparam int unsigned RC_MAX_CYC = ns_floor(T_RC_MAX_NS);
  localparam int unsigned PAGE_CLOSE_CYC = ns_floor(T_PAGE_CLOSE_US * 1000);
  localparam int unsigned PD_SETUP_CYC = ns_ceil(T_PD_SETUP_NS);
  localparam int unsigned PD_HOLD_CYC = ns_ceil(T_PD_HOLD_NS);
  localparam int unsigned DEEP_WAKE_CYC = ns_ceil(T_DEEP_WAKE_US * 1000);
  localparam int unsigned PAR_WAKE_CYC = ns_ceil(T_PAR_WAKE_US * 1000);

  // Program sequence steps
  localparam logic [2:0] PROG_RD_TOP = 3'h0;
  localparam logic [2:0] PROG_ZERO = 3'h3;
  localparam logic [2:0] PROG_CFG = 3'h4;
  localparam logic [2:0] PROG_LAST = 3'h5;

  typedef enum logic [2:0] {
    CMD_READ = 3'h0,
    CMD_WRITE = 3'h1,
    CMD_PAGE = 3'h2,
    CMD_SLEEP = 3'h3,
    CMD_WAKE = 3'h4,
    CMD_PROG = 3'h5
  } apac_cmd_t;

  // Encoded as the configuration value bits 1:0
  typedef enum logic [1:0] {
    PD_16M = 2'h0,
    PD_8M = 2'h1,
    PD_4M = 2'h2,
    PD_DEEP = 2'h3
  } apac_pd_mode_t;

  typedef enum logic [3:0] {
    ST_PWRUP = 4'h0,
    ST_IDLE = 4'h1,
    ST_RD_ADDR = 4'h2,
    ST_RD_OE = 4'h3,
    ST_RD_DATA = 4'h4,
    ST_WR_SET = 4'h5,
    ST_WR_PULSE = 4'h6,
    ST_WR_END = 4'h7,
    ST_GAP = 4'h8,
    ST_PD_SETUP = 4'h9,
    ST_PD_SLEEP = 4'ha,
    ST_WAKE = 4'hb
  } apac_state_t;

endpackage

// ### verilog/apac_timer.sv
`timescale 1ns/10ps
module apac_timer import apac_pkg::*; #(
  parameter int unsigned W = 16,
  parameter int unsigned RST_VAL = 0
) (
  input wire logic core_clk, // Core clock
  input wire logic rstn, // Async reset, active low
  input wire logic load, // Restart the count
  input wire logic [W-1:0] load_val, // Cycles to wait minus one
  output logic done // Count has run out
);

  logic [W-1:0] cnt_q;

  // Down counter that parks at zero
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= W'(RST_VAL);
    end else if (load) begin
      cnt_q <= load_val;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign done = (cnt_q == '0);

endmodule

// ### verilog/apac_pdc_map.sv
`timescale 1ns/10ps
module apac_pdc_map import apac_pkg::*; #(
  parameter int unsigned AW = ADDR_W,
  parameter int unsigned DW = DATA_W
) (
  input wire logic [1:0] mode, // Power-down mode code
  output logic [DW-1:0] cfg_data, // Value for the fifth cycle
  output logic [AW-1:0] cfg_addr // Address for the sixth cycle
);

  // Value uses the two low data bits only
  assign cfg_data = {{(DW-2){1'b0}}, mode};

  // Top two address bits carry the mode swapped, rest all high
  assign cfg_addr = {mode[0], mode[1], {(AW-2){1'b1}}};

endmodule

// ### tb/apac_psram_model.sv
`timescale 1ns/10ps
module apac_psram_model import apac_pkg::*; (
  input wire logic chip_select_n, // Select, low
  input wire logic sleep_control, // Low sleeps
  input wire logic out_en_n, // Output enable, low
  input wire logic write_en_n, // Write enable, low
  input wire logic upper_byte_sel_n, // Upper lane, low
  input wire logic lower_byte_sel_n, // Lower lane, low
  input wire logic [ADDR_W-1:0] addr_lines, // Address
  input wire logic [DATA_W-1:0] data_lines_o, // Host data
  input wire logic data_lines_oe, // Host drives data
  output logic [DATA_W-1:0] data_lines_i, // Data to host
  output logic [1:0] dev_mode // Programmed mode
);
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0] keep [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0] rd_w, lat_d, w;
  logic [DATA_W-1:0] park = 16'h0f0f;
  logic [ADDR_W-1:0] lat_a;
  logic [1:0] lat_b, cfg;
  logic wrote = 1'b0;
  int step = 0;
  realtime t_up = 0;
  // Pulse spans latest strobe fall to earliest rise
  wire wr_act = !chip_select_n && !write_en_n && sleep_control &&
    !(upper_byte_sel_n && lower_byte_sel_n);
  // Reads open when output enable is low while selected and awake, with write enable high
  wire rd_act = !chip_select_n && !out_en_n && write_en_n &&
    sleep_control;
  wire step_ok = (step == 3) ? (lat_d == 0) :
    (step == 4) ? (lat_d[15:2] == 0) : 1'b1;

  // Unwritten or lost words read as a fixed pattern
  function automatic logic [DATA_W-1:0] word(input logic [ADDR_W-1:0] a);
    return mem.exists(a) ? mem[a] : (a[15:0] ^ 16'hc3c3);
  endfunction

  // Released lanes never show the last value
  always @* begin
    rd_w = word(addr_lines);
    data_lines_i[15:8] = (rd_act && !upper_byte_sel_n) ? rd_w[15:8] :
      park[15:8];
    data_lines_i[7:0] = (rd_act && !lower_byte_sel_n) ? rd_w[7:0] :
      park[7:0];
  end
  always @(negedge rd_act) park = ~rd_w;

  // Capture during the pulse, store at its end
  always @* begin
    if (wr_act) begin
      lat_a = addr_lines;
      lat_d = data_lines_oe ? data_lines_o : ~data_lines_o;
      lat_b = {!upper_byte_sel_n, !lower_byte_sel_n};
    end
  end
  always @(negedge wr_act) begin
    w = word(lat_a);
    if (lat_b[1]) w[15:8] = lat_d[15:8];
    if (lat_b[0]) w[7:0] = lat_d[7:0];
    mem[lat_a] = w;
    wrote = 1'b1;
  end

  // Program sequence tracked at each access end
  always @(posedge chip_select_n) begin
    t_up = $realtime;
    if (step == 5 && !wrote && addr_lines == {cfg[0], cfg[1], 19'h7ffff})
      dev_mode = cfg;
    if (step == 4 && wrote && lat_a == '1 && step_ok)
      cfg = lat_d[1:0];
    if (!wrote && addr_lines == '1)
      step = 1;
    else if (wrote && lat_a == '1 && step > 0 && step < 5 && step_ok)
      step++;
    else
      step = 0;
    wrote = 1'b0;
  end

  // Sleep drops what the mode does not keep
  always @(negedge sleep_control) begin
    keep = mem;
    foreach (keep[a])
      if (dev_mode == 2'h3 || a >= (21'h40000 << (2'h2 - dev_mode)))
        mem.delete(a);
  end

  // Late write enable after deselect may hit a stray word
  always @(negedge write_en_n) begin
    if (chip_select_n && $realtime - t_up < 10)
      mem[lat_a ^ 21'h1] = ~lat_d;
  end

  initial dev_mode = 2'h3;
endmodule

// ### tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  import apac_pkg::*;
  localparam int WAKE_N = 20;
  localparam logic [20:0] PROBE [6] = '{21'h3ffff, 21'h40000, 21'h7ffff,
    21'h80000, 21'hfffff, 21'h100000};
  logic core_clk, rstn, req_valid, req_ready, rsp_valid, sleeping;
  logic chip_select_n, sleep_control, out_en_n, write_en_n, data_lines_oe;
  logic upper_byte_sel_n, lower_byte_sel_n;
  logic [2:0] req_cmd;
  logic [1:0] req_be, req_mode, pd_mode, dev_mode, cur_mode;
  logic [ADDR_W-1:0] req_addr, addr_lines, a, pg;
  logic [DATA_W-1:0] req_wdata, rsp_rdata, data_lines_i, data_lines_o;
  logic [DATA_W-1:0] mirror [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0] keep [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0] rq [$];
  int miscompares, n_compared, cycles, quiet, need;
  bit waking;

  apac_ctrl #(.DEEP_WAKE_CYCLES(WAKE_N)) dut_u (
    .core_clk, .rstn, .req_valid, .req_ready, .req_cmd, .req_addr,
    .req_wdata, .req_be, .req_mode, .rsp_valid, .rsp_rdata, .sleeping,
    .pd_mode, .chip_select_n, .sleep_control, .out_en_n, .write_en_n,
    .upper_byte_sel_n, .lower_byte_sel_n, .addr_lines, .data_lines_i,
    .data_lines_o, .data_lines_oe);
  apac_psram_model mem_u (
    .chip_select_n, .sleep_control, .out_en_n, .write_en_n,
    .upper_byte_sel_n, .lower_byte_sel_n, .addr_lines, .data_lines_o,
    .data_lines_oe, .data_lines_i, .dev_mode);

  // Free-running core clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  function automatic logic [DATA_W-1:0] exp_rd(input logic [ADDR_W-1:0] x);
    return mirror.exists(x) ? mirror[x] : (x[15:0] ^ 16'hc3c3);
  endfunction
  function automatic logic [DATA_W-1:0] lanes(input logic [1:0] b);
    return {{8{b[1]}}, {8{b[0]}}};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Hold the request until ready is seen at the taking edge
  task automatic req(input logic [2:0] c, input logic [ADDR_W-1:0] x,
      input logic [DATA_W-1:0] d, input logic [1:0] b, input logic [1:0] m);
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_addr <= x;
    req_wdata <= d;
    req_be <= b;
    req_mode <= m;
    @(negedge core_clk);
    while (req_ready !== 1'b1) @(negedge core_clk);
    @(posedge core_clk);
    req_valid <= 1'b0;
  endtask
  task automatic idle();
    @(negedge core_clk);
    while (req_ready !== 1'b1) @(negedge core_clk);
  endtask
  task automatic wait_rsp(input int n);
    repeat (100) if (rq.size() < n) @(negedge core_clk);
    chk(rq.size(), n);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] x, input logic [DATA_W-1:0] d,
      input logic [1:0] b);
    logic [DATA_W-1:0] w;
    w = exp_rd(x);
    if (b[1]) w[15:8] = d[15:8];
    if (b[0]) w[7:0] = d[7:0];
    mirror[x] = w;
    req(CMD_WRITE, x, d, b, 2'h0);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] x, input logic [1:0] b);
    rq.delete();
    req(CMD_READ, x, '0, b, 2'h0);
    wait_rsp(1);
    chk(rq[0] & lanes(b), exp_rd(x) & lanes(b));
  endtask
  task automatic nap();
    req(CMD_SLEEP, '0, '0, 2'h3, 2'h0);
    idle();
    chk({sleep_control, sleeping}, 2'h1);
    keep = mirror;
    foreach (keep[k])
      if (cur_mode == 2'h3 || k >= (21'h40000 << (2'h2 - cur_mode)))
        mirror.delete(k);
  endtask

  // Responses, quiet time before the first access after wake, hang limit
  always @(negedge core_clk) begin
    cycles++;
    need = (cur_mode == 2'h3) ? WAKE_N : PAR_WAKE_CYC;
    if (rsp_valid === 1'b1)
      rq.push_back(rsp_rdata);
    if (rstn !== 1'b1 || sleep_control !== 1'b1) begin
      waking = 1'b1;
      quiet = 0;
    end else if (waking && chip_select_n === 1'b1) begin
      quiet++;
    end else if (waking) begin
      waking = 1'b0;
      chk(quiet >= need, 1);
    end
    if (cycles > 30000) begin
      miscompares++;
      print_verdict();
    end
  end

  initial begin
    rstn = 1'b0;
    req_valid = 1'b0;
    req_cmd = 3'h0;
    req_addr = '0;
    req_wdata = '0;
    req_be = 2'h0;
    req_mode = 2'h0;
    cur_mode = 2'h3;
    void'($urandom(11));
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    idle();
    // Stray wake is ignored, reads while asleep are dropped
    rq.delete();
    req(CMD_WAKE, '0, '0, 2'h3, 2'h0);
    nap();
    req(CMD_READ, 21'h5, '0, 2'h3, 2'h0);
    repeat (10) @(negedge core_clk);
    chk(rq.size(), 0);
    req(CMD_WAKE, '0, '0, 2'h3, 2'h0);
    $display("test dropped commands done");
    // Random byte writes, each read back at once, plus split lanes
    for (int i = 0; i < 16; i++) begin
      a = ADDR_W'($urandom());
      wr(a, DATA_W'($urandom()), 2'($urandom_range(3, 1)));
      rd(a, 2'($urandom_range(3, 1)));
    end
    wr(21'h1ffffe, 16'hbeef, 2'h1);
    wr(21'h1ffffe, 16'h1234, 2'h2);
    rd(21'h1ffffe, 2'h3);
    $display("test random read write done");
    // Page read starting mid-page wraps inside the page
    pg = ADDR_W'($urandom()) | 21'h5;
    for (int i = 0; i < 8; i++)
      wr({pg[20:3], 3'(i)}, DATA_W'($urandom()), 2'h3);
    rq.delete();
    req(CMD_PAGE, pg, '0, 2'h3, 2'h0);
    wait_rsp(8);
    for (int i = 0; i < 8; i++)
      chk(rq[i], exp_rd({pg[20:3], 3'(pg[2:0] + i)}));
    $display("test page read done");
    // Each mode: program, sleep, wake, check what survived
    for (int m = 0; m < 4; m++) begin
      foreach (PROBE[k])
        wr(PROBE[k], DATA_W'($urandom()), 2'h3);
      rq.delete();
      req(CMD_PROG, '0, '0, 2'h3, 2'(m));
      wait_rsp(1);
      idle();
      mirror[21'h1fffff] = 16'(m);
      cur_mode = 2'(m);
      chk(rq[0], exp_rd({cur_mode[0], cur_mode[1], 19'h7ffff}));
      chk(pd_mode, cur_mode);
      chk(dev_mode, cur_mode);
      nap();
      req(CMD_WAKE, '0, '0, 2'h3, 2'h0);
      foreach (PROBE[k])
        rd(PROBE[k], 2'h3);
      $display("test power-down mode %0d done", m);
    end
    print_verdict();
  end
endmodule
